// >>> core/iss_consts.vh
// constants for the two-wire slave engine
`ifndef ISS_CONSTS_VH
`define ISS_CONSTS_VH

// slave modes of the mode select field
`define ISS_MODE_7B 4'h6
`define ISS_MODE_10B 4'h7
`define ISS_MODE_7B_SP 4'he
`define ISS_MODE_10B_SP 4'hf
`define ISS_MODE_TENBIT 0
`define ISS_MODE_SP_IRQ 3

// engine states
`define ISS_ST_IDLE 3'h0
`define ISS_ST_RECV 3'h1
`define ISS_ST_ACK 3'h2
`define ISS_ST_TX 3'h3
`define ISS_ST_TXACK 3'h4
`define ISS_ST_TXFALL 3'h5

// byte phases
`define ISS_PH_ADDR1 2'h0
`define ISS_PH_ADDR2 2'h1
`define ISS_PH_DATA 2'h2
`define ISS_PH_TX 2'h3

// byte framing
`define ISS_BYTE_BITS 4'h8
`define ISS_LAST_TX_BIT 4'h7
`define ISS_TEN_HDR 5'h1e

`endif

// >>> core/iss_sync.v
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module iss_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // asynchronous input and synchronised output
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> core/iss_cond.v
// bus condition detector: scl edges, start and stop
`timescale 1ns/1ns
module iss_cond (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // synchronised bus levels
  input wire scl_s,
  input wire sda_s,
  // delayed levels and event pulses
  output reg scl_lvl,
  output reg sda_lvl,
  output reg scl_rise,
  output reg scl_fall,
  output reg start_ev,
  output reg stop_ev
);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      start_ev <= 1'b0;
      stop_ev <= 1'b0;
    end else if (clk_en) begin
      scl_lvl <= scl_s;
      sda_lvl <= sda_s;
      scl_rise <= scl_s & ~scl_lvl;
      scl_fall <= ~scl_s & scl_lvl;
      // sda moving while scl stays high
      start_ev <= scl_s & scl_lvl & sda_lvl & ~sda_s; // R25
      stop_ev <= scl_s & scl_lvl & ~sda_lvl & sda_s; // R25
    end
  end

endmodule

// >>> core/iss_engine.v
// two-wire slave engine: addressing, receive, transmit, clock stretching
//
// Summary of operation
// R1: flag interrupt on each address match; on start/stop too in those modes.
// R2: on matched address or data byte, acknowledge and copy shift into buffer.
// R3: buffer full or overflow set: no acknowledge, no load, interrupt still.
// R4: buffer read clears buffer full; overflow stays until firmware clears it.
// R5: after start, shift eight bits in, sampling sda on rising scl.
// R6: compare shift bits 7:1 to own address at eighth scl fall.
// R7: clean match loads buffer, sets full, acks; interrupt at ninth fall.
// R8: master sends 11110, two top bits, write, then low address byte.
// R9: high byte sets irq, full, update; own address write clears update.
// R10: low byte sets them again; own address write restores and releases.
// R11: after repeated start, read high byte sets only irq and full.
// R12: write address match clears read/write bit, loads buffer, pulls sda low.
// R13: interrupt once per byte; only firmware clears it; status shows kind.
// R14: stretch enable holds scl after each received data byte until release.
// R15: read address match sets read/write bit, acks, always holds scl.
// R16: transmit write loads shift register; bits leave on falling scl.
// R17: master ack latched at ninth rise; nack resets status and idles.
// R18: transmit sets interrupt at ninth falling edge of each byte; a byte the master nacks sets no interrupt.
// R19: 7-bit receive, stretch on, full at ninth fall clears clock release.
// R20: buffer emptied before ninth fall means no stretch; release settable anytime.
// R21: 10-bit address phase stretches while update is set; own write releases.
// R22: buffer-full stretching applies to data bytes only, not addresses.
// R23: four-bit mode field picks 7/10-bit with optional start/stop interrupts.
// R24: clock release one frees scl; zero pulls scl low. Code pulls it only outside idle, once scl is already low.
// R25: scl and sda synchronised; start/stop are sda moves with scl high.
// R26: pins are open drain only: pulled low or released.
`timescale 1ns/1ns
`include "iss_consts.vh"
module iss_engine (
  // clock, reset, freeze
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // bus pins, open drain
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  // firmware control
  input wire port_enable,
  input wire [3:0] mode_select_field,
  input wire stretch_enable,
  input wire [7:0] own_address_in,
  input wire own_address_wr,
  input wire [7:0] buf_wr_data,
  input wire buf_wr,
  input wire buf_rd,
  input wire clock_release_set,
  input wire clock_release_clr,
  input wire overflow_clr,
  input wire irq_clr,
  // firmware status
  output reg [7:0] rx_tx_buffer,
  output reg [7:0] own_address_register,
  output reg buffer_full_flag,
  output reg receive_overflow_flag,
  output reg port_interrupt_flag,
  output reg address_update_flag,
  output reg clock_release,
  output reg rw_status,
  output reg data_not_address,
  output reg start_seen,
  output reg stop_seen
);

  // ****************************************
  // pin synchronisation and bus events
  // ****************************************
  wire [1:0] pins_s;
  wire scl_lvl;
  wire sda_lvl;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;

  iss_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  ); // R25

  iss_cond u_cond (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .scl_s(pins_s[1]),
    .sda_s(pins_s[0]),
    .scl_lvl(scl_lvl),
    .sda_lvl(sda_lvl),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_ev(start_ev),
    .stop_ev(stop_ev)
  );

  // ****************************************
  // mode decode and address match
  // ****************************************
  reg [2:0] state;
  reg [1:0] phase;
  reg [3:0] bit_cnt;
  reg [7:0] shift_register;
  reg ack_ok;
  reg is_read;
  reg addr10_ok;

  wire slave_mode = (mode_select_field == `ISS_MODE_7B) |
                    (mode_select_field == `ISS_MODE_10B) |
                    (mode_select_field == `ISS_MODE_7B_SP) |
                    (mode_select_field == `ISS_MODE_10B_SP); // R23
  wire tenbit = mode_select_field[`ISS_MODE_TENBIT]; // R23
  wire sp_irq = mode_select_field[`ISS_MODE_SP_IRQ]; // R23
  wire hi_match = (shift_register[7:3] == `ISS_TEN_HDR) &
                  (shift_register[7:1] == own_address_register[7:1]); // R8
  wire seven_match = shift_register[7:1] == own_address_register[7:1]; // R6
  reg addr_match;
  wire busy = buffer_full_flag | receive_overflow_flag;
  wire bf_at_fall = buffer_full_flag & ~buf_rd;
  wire hold_scl = (~clock_release & (state != `ISS_ST_IDLE)) |
                  address_update_flag;

  always @* begin
    case (phase)
      `ISS_PH_ADDR1:
        addr_match = tenbit ? (hi_match & (~shift_register[0] | addr10_ok)) : seven_match;
      `ISS_PH_ADDR2:
        addr_match = shift_register == own_address_register;
      `ISS_PH_DATA:
        addr_match = 1'b1;
      default:
        addr_match = 1'b0;
    endcase
  end

  // ****************************************
  // engine
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= `ISS_ST_IDLE;
      phase <= `ISS_PH_ADDR1;
      bit_cnt <= 4'h0;
      shift_register <= 8'h00;
      ack_ok <= 1'b0;
      is_read <= 1'b0;
      addr10_ok <= 1'b0;
      scl_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      rx_tx_buffer <= 8'h00;
      own_address_register <= 8'h00;
      buffer_full_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_interrupt_flag <= 1'b0;
      address_update_flag <= 1'b0;
      clock_release <= 1'b1;
      rw_status <= 1'b0;
      data_not_address <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else if (clk_en) begin
      // pins only ever pull low
      scl_out <= 1'b0; // R26
      sda_out <= 1'b0; // R26
      // firmware side; hardware sets below win the same cycle
      if (own_address_wr) begin
        own_address_register <= own_address_in;
        address_update_flag <= 1'b0; // R9 R10 R21
      end
      if (buf_rd) begin
        buffer_full_flag <= 1'b0; // R4
      end
      if (overflow_clr) begin
        receive_overflow_flag <= 1'b0; // R4
      end
      if (irq_clr) begin
        port_interrupt_flag <= 1'b0; // R13
      end
      if (clock_release_clr) begin
        clock_release <= 1'b0;
      end
      if (clock_release_set) begin
        clock_release <= 1'b1; // R20
      end
      if (buf_wr) begin
        rx_tx_buffer <= buf_wr_data;
        buffer_full_flag <= 1'b1;
        if (state == `ISS_ST_TX && bit_cnt == 4'h0) begin
          shift_register <= buf_wr_data; // R16
        end
      end
      // scl pulled only once already low, then held until released
      scl_oe_n <= ~(hold_scl & (~scl_lvl | ~scl_oe_n)); // R14 R24

      if (!port_enable || !slave_mode) begin
        state <= `ISS_ST_IDLE;
        phase <= `ISS_PH_ADDR1;
        bit_cnt <= 4'h0;
        addr10_ok <= 1'b0;
        sda_oe_n <= 1'b1;
        scl_oe_n <= 1'b1;
        clock_release <= 1'b1;
        address_update_flag <= 1'b0;
        start_seen <= 1'b0;
        stop_seen <= 1'b0;
      end else if (start_ev) begin
        state <= `ISS_ST_RECV; // R5
        phase <= `ISS_PH_ADDR1;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
        if (sp_irq) begin
          port_interrupt_flag <= 1'b1; // R1
        end
      end else if (stop_ev) begin
        state <= `ISS_ST_IDLE;
        phase <= `ISS_PH_ADDR1;
        addr10_ok <= 1'b0;
        sda_oe_n <= 1'b1;
        start_seen <= 1'b0;
        stop_seen <= 1'b1;
        if (sp_irq) begin
          port_interrupt_flag <= 1'b1; // R1
        end
      end else begin
        case (state)
          `ISS_ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          `ISS_ST_RECV: begin
            if (scl_rise) begin
              shift_register <= {shift_register[6:0], sda_lvl}; // R5
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `ISS_BYTE_BITS) begin
              if (!addr_match) begin
                state <= `ISS_ST_IDLE; // R6
              end else begin
                state <= `ISS_ST_ACK;
                data_not_address <= phase == `ISS_PH_DATA; // R13
                is_read <= (phase == `ISS_PH_ADDR1) & shift_register[0];
                if (phase == `ISS_PH_ADDR1) begin
                  rw_status <= shift_register[0]; // R12 R15
                end
                if (busy) begin
                  ack_ok <= 1'b0; // R3
                  if (phase == `ISS_PH_DATA) begin
                    receive_overflow_flag <= 1'b1;
                  end
                end else begin
                  ack_ok <= 1'b1;
                  rx_tx_buffer <= shift_register; // R2 R7
                  buffer_full_flag <= 1'b1; // R7
                  sda_oe_n <= 1'b0; // R2 R12
                end
              end
            end
          end
          `ISS_ST_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              port_interrupt_flag <= 1'b1; // R1 R3 R7 R13
              bit_cnt <= 4'h0;
              state <= `ISS_ST_RECV;
              case (phase)
                `ISS_PH_ADDR1: begin
                  if (!ack_ok) begin
                    state <= `ISS_ST_IDLE;
                  end else if (is_read) begin
                    phase <= `ISS_PH_TX; // R11 R15
                    state <= `ISS_ST_TX;
                    clock_release <= 1'b0; // R15
                  end else if (tenbit) begin
                    phase <= `ISS_PH_ADDR2;
                    address_update_flag <= 1'b1; // R9 R21
                  end else begin
                    phase <= `ISS_PH_DATA;
                  end
                end
                `ISS_PH_ADDR2: begin
                  if (ack_ok) begin
                    phase <= `ISS_PH_DATA;
                    addr10_ok <= 1'b1;
                    address_update_flag <= 1'b1; // R10 R21
                  end else begin
                    state <= `ISS_ST_IDLE;
                  end
                end
                default: begin
                  if (stretch_enable && bf_at_fall) begin
                    clock_release <= 1'b0; // R14 R19 R20 R22
                  end
                end
              endcase
            end
          end
          `ISS_ST_TX: begin
            if (scl_fall && bit_cnt == `ISS_LAST_TX_BIT) begin
              sda_oe_n <= 1'b1;
              // a firmware write in this same cycle keeps the buffer full
              buffer_full_flag <= buf_wr;
              state <= `ISS_ST_TXACK;
            end else if (scl_fall) begin
              shift_register <= {shift_register[6:0], 1'b0}; // R16
              bit_cnt <= bit_cnt + 4'h1;
            end else begin
              sda_oe_n <= shift_register[7]; // R16 R26
            end
          end
          `ISS_ST_TXACK: begin
            if (scl_rise) begin
              if (sda_lvl) begin
                state <= `ISS_ST_IDLE; // R17
                phase <= `ISS_PH_ADDR1;
                rw_status <= 1'b0;
                data_not_address <= 1'b0;
                start_seen <= 1'b0;
                stop_seen <= 1'b0;
              end else begin
                state <= `ISS_ST_TXFALL; // R17
              end
            end
          end
          `ISS_ST_TXFALL: begin
            if (scl_fall) begin
              port_interrupt_flag <= 1'b1; // R18
              data_not_address <= 1'b1;
              bit_cnt <= 4'h0;
              state <= `ISS_ST_TX;
              if (!bf_at_fall) begin
                clock_release <= 1'b0; // R17
              end
            end
          end
          default: begin
            state <= `ISS_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// >>> bench/iss_master.sv
// bus master model for the two-wire slave engine
`timescale 1ns/1ns
module iss_master (
  // wire levels
  input wire scl_w,
  input wire sda_w,
  // open-drain releases, high lets the pull-up win
  output reg scl_rel,
  output reg sda_rel
);
  // ****
  // bus tasks, quarter bit of 40 ns
  // ****
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // release scl and wait out any stretch, bounded
  task hi;
    int n;
    begin
      n = 0;
      scl_rel = 1'b1;
      while (!scl_w && n < 4000) begin
        #10;
        n++;
      end
      #40;
    end
  endtask
  task start;
    begin
      sda_rel = 1'b1;
      #80;
      hi();
      sda_rel = 1'b0;
      #40;
      scl_rel = 1'b0;
      #40;
    end
  endtask
  task stop;
    begin
      sda_rel = 1'b0;
      #40;
      hi();
      sda_rel = 1'b1;
      #80;
    end
  endtask
  task bit_io(input logic b, output logic r);
    begin
      sda_rel = b;
      #40;
      hi();
      r = sda_w;
      #40;
      scl_rel = 1'b0;
      #40;
    end
  endtask
  task wbyte(input logic [7:0] v, output logic ack_n);
    logic r;
    begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(v[i], r);
      end
      bit_io(1'b1, ack_n);
    end
  endtask
  task rbyte(input logic ack_n, output logic [7:0] v);
    logic r;
    begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        v[i] = r;
      end
      bit_io(ack_n, r);
    end
  endtask
endmodule

// >>> bench/iss_engine_chk_sva.sv
// assertions on the ports of the two-wire slave engine
`timescale 1ns/1ns
module iss_engine_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // firmware side
  input wire logic port_enable,
  input wire logic [3:0] mode_select_field,
  input wire logic buf_rd,
  input wire logic buf_wr,
  input wire logic own_address_wr,
  input wire logic clock_release_set,
  input wire logic overflow_clr,
  input wire logic irq_clr,
  input wire logic buffer_full_flag,
  input wire logic receive_overflow_flag,
  input wire logic port_interrupt_flag,
  input wire logic address_update_flag,
  input wire logic clock_release
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_start;
    port_enable && clk_en && mode_select_field[3:1] == 3'h7 && scl_in && $fell(sda_in);
  endsequence
  sequence s_free;
    (clock_release && !address_update_flag) [*2];
  endsequence
  sequence s_held;
    (!clock_release && !scl_in && clk_en) [*8];
  endsequence
  property p_open_drain;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  property p_sda_moves;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  property p_rd_full;
    buf_rd && !buf_wr && clk_en |=> !buffer_full_flag;
  endproperty
  property p_ovf_keep;
    receive_overflow_flag && !overflow_clr |=> receive_overflow_flag;
  endproperty
  property p_irq_keep;
    port_interrupt_flag && !irq_clr |=> port_interrupt_flag;
  endproperty
  property p_ua_clr;
    own_address_wr && clk_en |=> !address_update_flag;
  endproperty
  property p_rel_set;
    clock_release_set && clk_en |=> clock_release;
  endproperty
  property p_free;
    s_free |-> scl_oe_n;
  endproperty
  property p_held;
    s_held |-> !scl_oe_n;
  endproperty
  property p_start_irq;
    s_start |-> ##[1:8] port_interrupt_flag;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  a_sda_moves: assert property (p_sda_moves) else $error("sda moved, scl high");
  a_rd_full: assert property (p_rd_full) else $error("read kept full");
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
  a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
  a_ua_clr: assert property (p_ua_clr) else $error("update stayed");
  a_rel_set: assert property (p_rel_set) else $error("release not set");
  a_free: assert property (p_free) else $error("scl held when free");
  a_held: assert property (p_held) else $error("scl not held");
  a_start_irq: assert property (p_start_irq) else $error("no start irq");
endmodule
bind iss_engine iss_engine_chk u_chk (.*);

// >>> bench/test_i2c_slave_engine.sv
// self-checking bench for the two-wire slave engine
`timescale 1ns/1ns
module test_i2c_slave_engine;
  // ****
  // stimulus, wires, helpers
  // ****
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic port_enable = 1'b0;
  logic stretch_enable = 1'b0;
  logic [3:0] mode_select_field = 4'h6;
  logic [7:0] own_address_in = 8'h00;
  logic [7:0] buf_wr_data = 8'h00;
  logic buf_rd = 1'b0, buf_wr = 1'b0, own_address_wr = 1'b0, clock_release_set = 1'b0;
  logic clock_release_clr = 1'b0, overflow_clr = 1'b0, irq_clr = 1'b0;
  wire m_scl, m_sda, scl_out, scl_oe_n, sda_out, sda_oe_n;
  wire scl_in = m_scl & scl_oe_n;
  wire sda_in = m_sda & sda_oe_n;
  wire [7:0] rx_tx_buffer, own_address_register;
  wire buffer_full_flag, receive_overflow_flag, port_interrupt_flag, address_update_flag;
  wire clock_release, rw_status, data_not_address, start_seen, stop_seen;
  int mismatches = 0, compares = 0, cyc = 0;
  logic [31:0] seed = 32'd73;
  logic [7:0] q[$];
  logic a;
  logic [7:0] d;
  iss_engine u_dut (.*);
  iss_master u_mst (.scl_w(scl_in), .sda_w(sda_in), .scl_rel(m_scl), .sda_rel(m_sda));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bits: irq, ovf, rel clr, rel set, own wr, buf wr, buf rd
  task pulse(input logic [6:0] m);
    @(posedge core_clk);
    {irq_clr, overflow_clr, clock_release_clr, clock_release_set, own_address_wr, buf_wr,
      buf_rd} <= m;
    @(posedge core_clk);
    {irq_clr, overflow_clr, clock_release_clr, clock_release_set, own_address_wr, buf_wr,
      buf_rd} <= 7'h00;
    @(negedge core_clk);
  endtask
  task set_own(input logic [7:0] v);
    @(posedge core_clk);
    own_address_in <= v;
    pulse(7'h04);
  endtask
  // master writes a byte; model keeps the last loaded byte
  task wr(input logic [7:0] v, input logic ack_n, input logic irq_e);
    u_mst.wbyte(v, a);
    @(negedge core_clk);
    if (!ack_n) q.push_back(v);
    chk(a, ack_n);
    chk(port_interrupt_flag, irq_e);
    chk(rx_tx_buffer, q[$]);
    pulse(7'h40);
  endtask
  // firmware loads a random byte, master reads it
  task tx(input logic ack_n);
    seed = xs(seed);
    @(posedge core_clk);
    buf_wr_data <= seed[7:0];
    pulse(7'h02);
    pulse(7'h08);
    u_mst.rbyte(ack_n, d);
    @(negedge core_clk);
    chk(d, buf_wr_data);
    chk(rw_status, !ack_n);
    chk(port_interrupt_flag, !ack_n);
    chk(clock_release, ack_n);
    pulse(7'h40);
  endtask
  task stop_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    port_enable <= 1'b1;
    q.push_back(8'h00);
    set_own(8'h54);
    pulse(7'h10);
    chk(clock_release, 0);
    pulse(7'h08);
    chk(clock_release, 1);
    u_mst.start();
    wr(8'h54, 0, 1);
    chk(rw_status, 0);
    pulse(7'h01);
    seed = xs(seed);
    wr(seed[7:0], 0, 1);
    chk(data_not_address, 1);
    seed = xs(seed);
    wr(seed[7:0], 1, 1);
    chk(receive_overflow_flag, 1);
    pulse(7'h01);
    chk(buffer_full_flag, 0);
    chk(receive_overflow_flag, 1);
    pulse(7'h20);
    chk(receive_overflow_flag, 0);
    u_mst.stop();
    chk(stop_seen, 1);
    $display("test 1 done");
    @(posedge core_clk);
    stretch_enable <= 1'b1;
    u_mst.start();
    wr(8'h54, 0, 1);
    chk(clock_release, 1);
    pulse(7'h01);
    seed = xs(seed);
    wr(seed[7:0], 0, 1);
    chk(clock_release, 0);
    chk(scl_oe_n, 0);
    pulse(7'h01);
    pulse(7'h08);
    u_mst.stop();
    u_mst.start();
    wr(8'h56, 1, 0);
    u_mst.stop();
    $display("test 2 done");
    u_mst.start();
    wr(8'h55, 0, 1);
    chk(rw_status, 1);
    chk(clock_release, 0);
    pulse(7'h01);
    tx(0);
    tx(1);
    u_mst.stop();
    $display("test 3 done");
    @(posedge core_clk);
    mode_select_field <= 4'h7;
    set_own(8'hf2);
    u_mst.start();
    wr(8'hf2, 0, 1);
    chk(address_update_flag, 1);
    chk(scl_oe_n, 0);
    pulse(7'h01);
    set_own(8'ha5);
    chk(address_update_flag, 0);
    chk(own_address_register, 8'ha5);
    wr(8'ha5, 0, 1);
    chk(address_update_flag, 1);
    pulse(7'h01);
    set_own(8'hf2);
    seed = xs(seed);
    wr(seed[7:0], 0, 1);
    pulse(7'h01);
    pulse(7'h08);
    u_mst.start();
    wr(8'hf3, 0, 1);
    chk(address_update_flag, 0);
    pulse(7'h01);
    tx(1);
    u_mst.stop();
    $display("test 4 done");
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      mode_select_field <= {k[1], 2'b11, k[0]};
      pulse(7'h40);
      u_mst.start();
      chk(start_seen, 1);
      chk(port_interrupt_flag, k[1]);
      u_mst.stop();
      chk(stop_seen, 1);
    end
    $display("test 5 done");
    @(posedge core_clk);
    mode_select_field <= 4'h8;
    u_mst.start();
    chk(start_seen, 0);
    u_mst.stop();
    chk(stop_seen, 0);
    @(posedge core_clk);
    clk_en <= 1'b0;
    pulse(7'h40);
    chk(port_interrupt_flag, 1);
    @(posedge core_clk);
    clk_en <= 1'b1;
    pulse(7'h40);
    chk(port_interrupt_flag, 0);
    $display("test 6 done");
    stop_test();
  end
endmodule
